/* File: hw/iew_apb_master.sv */
// two-wire bus master ordered by software over apb
module iew_apb_master (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // link
  iew_link_if.host_mp link,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    iew_pkg::iew_host_state_type st;
    logic [2:0] cmd;
    logic ack_send;
    logic [7:0] tx;
    logic [8:0] sh;
    logic [3:0] bitn;
    logic [1:0] qtr;
    logic [3:0] div;
    logic [7:0] rx;
    logic ack_ok;
    logic srst_two;
    logic scl_drv;
    logic sda_drv;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } iew_host_regs_type;

  iew_host_regs_type q;
  iew_host_regs_type d;
  logic s_sda;

  iew_sync2 #(.W(1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.sda),
    .dout(s_sda)
  );

  // ****************************************************************
  // register access and bit sequencer
  // ****************************************************************
  always_comb begin
    logic access;
    logic mapped;
    logic tick;
    logic busy;
    d = q;
    access = psel & penable;
    mapped = paddr == iew_pkg::REG_CMD || paddr == iew_pkg::REG_TX
             || paddr == iew_pkg::REG_STAT;
    busy = q.st != iew_pkg::HS_IDLE;
    tick = q.div == iew_pkg::QTR_LAST;
    // one wait state so read data comes from a flop
    d.pready = access & ~q.pready;
    if (access && !q.pready) begin
      d.pslverr = ~mapped;
      case (paddr)
        iew_pkg::REG_CMD: d.prdata = {23'h0, q.ack_send, 5'h0, q.cmd};
        iew_pkg::REG_TX: d.prdata = {24'h0, q.tx};
        iew_pkg::REG_STAT: d.prdata = {16'h0, q.rx, 6'h0, q.ack_ok, busy};
        default: d.prdata = 32'h0;
      endcase
    end
    d.div = (busy && !tick) ? q.div + 4'h1 : 4'h0;
    if (access && q.pready && pwrite) begin
      if (paddr == iew_pkg::REG_TX) begin
        d.tx = pwdata[7:0];
      end else if (paddr == iew_pkg::REG_CMD && !busy) begin
        // commands while busy are dropped
        d.cmd = pwdata[2:0];
        d.ack_send = pwdata[iew_pkg::CMD_ACK_BIT];
        d.qtr = 2'h0;
        d.bitn = 4'h0;
        d.srst_two = 1'b0;
        case (pwdata[2:0])
          iew_pkg::CMD_START, iew_pkg::CMD_SRST: d.st = iew_pkg::HS_START;
          iew_pkg::CMD_STOP: d.st = iew_pkg::HS_STOP;
          iew_pkg::CMD_WRITE: begin
            d.sh = {q.tx, 1'b1};  // see R8 R10
            d.st = iew_pkg::HS_BITS;
          end
          iew_pkg::CMD_READ: begin
            d.sh = {8'hff, ~pwdata[iew_pkg::CMD_ACK_BIT]};
            d.st = iew_pkg::HS_BITS;
          end
          default: d.st = iew_pkg::HS_IDLE;
        endcase
      end
    end
    if (busy && tick) begin
      d.qtr = q.qtr + 2'h1;
      case (q.st)
        iew_pkg::HS_START: begin
          // sda falls while scl is high; see R19
          case (q.qtr)
            2'h0: d.sda_drv = 1'b0;
            2'h1: d.scl_drv = 1'b0;
            2'h2: d.sda_drv = 1'b1;
            default: begin
              d.scl_drv = 1'b1;
              if (q.cmd != iew_pkg::CMD_SRST) begin
                d.st = iew_pkg::HS_IDLE;
              end else if (!q.srst_two) begin
                // nine released clocks; see R2
                d.sh = 9'h1ff;
                d.bitn = 4'h0;
                d.st = iew_pkg::HS_BITS;
              end else begin
                d.st = iew_pkg::HS_STOP;
              end
            end
          endcase
        end
        iew_pkg::HS_STOP: begin
          // sda rises while scl is high; see R9 R19
          case (q.qtr)
            2'h0: d.sda_drv = 1'b1;
            2'h1: d.scl_drv = 1'b0;
            2'h2: d.sda_drv = 1'b0;
            default: d.st = iew_pkg::HS_IDLE;
          endcase
        end
        iew_pkg::HS_BITS: begin
          // data changes only with scl low; see R18 R19
          case (q.qtr)
            2'h0: d.sda_drv = ~q.sh[8];
            2'h1: d.scl_drv = 1'b0;
            2'h2: begin
              if (q.bitn == 4'h8) begin
                d.ack_ok = ~s_sda;  // see R13
              end else begin
                d.rx = {q.rx[6:0], s_sda};
              end
            end
            default: begin
              d.scl_drv = 1'b1;
              d.sh = {q.sh[7:0], 1'b1};
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == 4'h8) begin
                d.sda_drv = 1'b0;
                d.srst_two = q.cmd == iew_pkg::CMD_SRST;
                // see R2
                d.st = (q.cmd == iew_pkg::CMD_SRST) ? iew_pkg::HS_START : iew_pkg::HS_IDLE;
              end
            end
          endcase
        end
        default: d.st = iew_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: iew_pkg::HS_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = q.scl_drv;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_drv;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
endmodule

/* File: hw/iew_eeprom_dev.sv */
// two-wire eeprom slave: addressing, writes, write cycle, reads and identification_page lock
//
// Overview of operation
// R1 - standby after reset, read stop, write cycle
// R2 - start, nine clocks, start, stop resynchronises
// R3 - eight-bit device word, type 1010 array
// R4 - chip-select bits must equal address pins
// R5 - device word lsb selects read or write
// R6 - ack match; mismatch returns to standby
// R7 - write-inhibit pin high blocks all writes
// R8 - byte write: two address bytes, data
// R9 - stop starts write cycle, inputs ignored
// R10 - page write acks data until stop
// R11 - increment only low five address bits
// R12 - over 32 bytes wraps, overwriting page
// R13 - poll acked only after write cycle
// R14 - type 1011, a11..a10 zero: identification_page
// R15 - locked identification_page: data not acked
// R16 - lock: type 1011, a10, data bit1
// R17 - current, random and sequential reads supported
// R18 - eight bits, ack low on ninth
// R19 - start and stop framed by scl high
// R20 - write cycle at most five milliseconds
// R21 - inhibited write starts no write cycle
// R22 - id lock survives reset, never cleared
//
// Chosen here: the register offsets and register access over APB.
module iew_eeprom_dev #(
  parameter int WRITE_CYCLES = iew_pkg::WR_CYCLES,
  // arbitrary value, replace per part
  parameter logic [127:0] SERIAL_NUMBER = 128'h0
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // link
  iew_link_if.dev_mp link,
  // straps
  input wire logic chip_select_bit_2,
  input wire logic chip_select_bit_1,
  input wire logic chip_select_bit_0,
  input wire logic write_inhibit_pin,
  // status
  output logic standby,
  output logic write_busy
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    iew_pkg::iew_dev_state_type st;
    iew_pkg::iew_phase_type ph;
    logic [1:0] area;
    logic ext;
    logic rw;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [12:0] addr;
    logic mack;
    logic wr_flag;
    logic [iew_pkg::WCNT_W-1:0] wcnt;
    logic scl_p;
    logic sda_p;
    logic drv;
    logic standby;
    logic busy;
  } iew_dev_regs_type;

  iew_dev_regs_type q;
  iew_dev_regs_type d;
  logic [5:0] pins_s;
  logic s_scl;
  logic s_sda;
  logic s_wi;
  logic [2:0] s_cs;
  logic [7:0] array_mem [iew_pkg::MEM_BYTES];
  logic [7:0] id_mem [iew_pkg::ID_BYTES];
  // nonvolatile model: presetn never clears it, only power-up of the model does
  logic id_lock_q = 1'b0;
  logic we_mem;
  logic we_id;
  logic set_lock;
  logic [7:0] rd_byte;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bits outside the mask hold, bits inside count and roll over
  function automatic logic [12:0] addr_inc(input logic [12:0] a, input logic [12:0] m);
    logic [12:0] n;
    n = a + 13'h0001;
    return (a & ~m) | (n & m);
  endfunction

  function automatic logic [12:0] area_mask(input logic [1:0] ar);
    logic [12:0] m;
    m = iew_pkg::MASK_NONE;
    case (ar)
      iew_pkg::AREA_NORM: m = iew_pkg::MASK_FULL;
      iew_pkg::AREA_ID: m = iew_pkg::MASK_PAGE;
      iew_pkg::AREA_SN: m = iew_pkg::MASK_SN;
      default: m = iew_pkg::MASK_NONE;
    endcase
    return m;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  iew_sync2 #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({link.scl, link.sda, write_inhibit_pin,
          chip_select_bit_2, chip_select_bit_1, chip_select_bit_0}),
    .dout(pins_s)
  );
  assign s_scl = pins_s[5];
  assign s_sda = pins_s[4];
  assign s_wi = pins_s[3];
  assign s_cs = pins_s[2:0];

  // ****************************************************************
  // read data source
  // ****************************************************************
  always_comb begin
    case (q.area)
      iew_pkg::AREA_NORM: rd_byte = array_mem[q.addr];
      iew_pkg::AREA_ID: rd_byte = id_mem[q.addr[4:0]];
      iew_pkg::AREA_SN: rd_byte = SERIAL_NUMBER[{q.addr[3:0], 3'h0} +: 8];
      default: rd_byte = {7'h00, id_lock_q};
    endcase
  end

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ack;
    rise = s_scl & ~q.scl_p;
    fall = ~s_scl & q.scl_p;
    start = s_scl & q.scl_p & q.sda_p & ~s_sda;  // see R19
    stop = s_scl & q.scl_p & ~q.sda_p & s_sda;  // see R19
    ack = 1'b1;
    d = q;
    we_mem = 1'b0;
    we_id = 1'b0;
    set_lock = 1'b0;
    d.scl_p = s_scl;
    d.sda_p = s_sda;
    if (q.st == iew_pkg::DS_BUSY) begin
      // inputs are ignored, so polls see no ack until the count ends; see R9 R13
      d.wcnt = q.wcnt + 1'b1;
      if (q.wcnt == iew_pkg::WCNT_W'(WRITE_CYCLES - 1)) begin
        d.st = iew_pkg::DS_IDLE;  // see R20 R1
      end
    end else if (start) begin
      // any start outside the write cycle resynchronises, which also ends a soft reset; see R2
      d.st = iew_pkg::DS_RECV;
      d.ph = iew_pkg::PH_DEV;
      d.bits = 4'h0;
      d.drv = 1'b0;
    end else if (stop) begin
      d.drv = 1'b0;
      d.wcnt = '0;
      d.wr_flag = 1'b0;
      // see R9 R21 R1
      d.st = q.wr_flag ? iew_pkg::DS_BUSY : iew_pkg::DS_IDLE;
    end else begin
      case (q.st)
        iew_pkg::DS_RECV: begin
          if (rise) begin
            d.sh = {q.sh[6:0], s_sda};
            d.bits = q.bits + 4'h1;
          end else if (fall && q.bits == 4'h8) begin
            // a whole byte is in: decode it and choose the ack; see R18
            case (q.ph)
              iew_pkg::PH_DEV: begin
                // see R3 R4
                ack = (q.sh[7:4] == iew_pkg::TYPE_MEM || q.sh[7:4] == iew_pkg::TYPE_EXT)
                      && q.sh[3:1] == s_cs;
                d.rw = q.sh[0];  // see R5 R17
                d.ext = q.sh[4];
                if (!q.sh[4]) begin
                  d.area = iew_pkg::AREA_NORM;
                end else if (q.area == iew_pkg::AREA_NORM) begin
                  d.area = iew_pkg::AREA_ID;
                end
                d.ph = iew_pkg::PH_AHI;
              end
              iew_pkg::PH_AHI: begin
                d.addr[12:8] = q.sh[4:0];  // see R8
                if (q.ext) begin
                  // see R14 R16
                  if (q.sh[iew_pkg::HI_LOCK_BIT]) begin
                    d.area = iew_pkg::AREA_LOCK;
                  end else if (q.sh[iew_pkg::HI_SN_BIT]) begin
                    d.area = iew_pkg::AREA_SN;
                  end else begin
                    d.area = iew_pkg::AREA_ID;
                  end
                end
                d.ph = iew_pkg::PH_ALO;
              end
              iew_pkg::PH_ALO: begin
                d.addr[7:0] = q.sh;  // see R8
                d.ph = iew_pkg::PH_DATA;
              end
              iew_pkg::PH_DATA: begin
                // data bytes keep coming until stop; see R10
                case (q.area)
                  iew_pkg::AREA_NORM: begin
                    we_mem = ~s_wi;  // see R7
                  end
                  iew_pkg::AREA_ID: begin
                    ack = ~id_lock_q;  // see R15
                    we_id = ~s_wi & ~id_lock_q;
                  end
                  iew_pkg::AREA_LOCK: begin
                    set_lock = ~s_wi & q.sh[iew_pkg::LOCK_DATA_BIT];  // see R16 R22
                  end
                  default: begin
                  end
                endcase
                d.wr_flag = q.wr_flag | we_mem | we_id | set_lock;  // see R21
                // see R11 R12
                d.addr = addr_inc(q.addr, iew_pkg::MASK_PAGE);
              end
              default: d.ph = iew_pkg::PH_DEV;
            endcase
            d.bits = 4'h0;
            d.drv = ack;  // see R6 R18
            d.st = ack ? iew_pkg::DS_ACK : iew_pkg::DS_IDLE;  // see R6
          end
        end
        iew_pkg::DS_ACK: begin
          if (fall) begin
            d.drv = 1'b0;
            if (q.rw) begin
              d.sh = rd_byte;
              d.addr = addr_inc(q.addr, area_mask(q.area));
              d.drv = ~rd_byte[7];
              d.st = iew_pkg::DS_SEND;
            end else begin
              d.st = iew_pkg::DS_RECV;
            end
          end
        end
        iew_pkg::DS_SEND: begin
          // data leaves on the falling edge so it is stable across scl high
          if (fall) begin
            if (q.bits == 4'h7) begin
              d.drv = 1'b0;
              d.st = iew_pkg::DS_MACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.drv = ~q.sh[6];
              d.bits = q.bits + 4'h1;
            end
          end
        end
        iew_pkg::DS_MACK: begin
          if (rise) begin
            d.mack = ~s_sda;
          end else if (fall) begin
            // sequential read continues while the master acks; see R17
            d.bits = 4'h0;
            if (q.mack) begin
              d.sh = rd_byte;
              d.addr = addr_inc(q.addr, area_mask(q.area));
              d.drv = ~rd_byte[7];
              d.st = iew_pkg::DS_SEND;
            end else begin
              d.st = iew_pkg::DS_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
    d.standby = (d.st == iew_pkg::DS_IDLE);
    d.busy = (d.st == iew_pkg::DS_BUSY);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: iew_pkg::DS_IDLE, ph: iew_pkg::PH_DEV, standby: 1'b1,
             scl_p: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge pclk) begin
    if (we_mem) begin
      array_mem[q.addr] <= q.sh;
    end
    if (we_id) begin
      id_mem[q.addr[4:0]] <= q.sh;
    end
    if (set_lock) begin
      id_lock_q <= 1'b1;  // see R22
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.drv;
  assign standby = q.standby;
  assign write_busy = q.busy;
endmodule

/* File: hw/iew_sync2.sv */
// two flip-flop synchroniser for pins arriving from outside the pclk domain
module iew_sync2 #(
  parameter int W = 1
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iew_sync_regs_type;

  iew_sync_regs_type q;
  iew_sync_regs_type d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // lines idle high, so a reset to ones shows no false edge at release
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

/* File: inc/iew_link_if.sv */
// open-drain two-wire link joining the master end and the eeprom end
interface iew_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-up: a line is low only while someone drives a zero
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev_mp (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host_mp (input scl, input sda, output host_scl_o, output host_scl_oe,
                   output host_sda_o, output host_sda_oe);
endinterface

/* File: inc/iew_pkg.sv */
// shared constants and types for the two-wire eeprom device and its apb master
package iew_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_WR_MS = 5;
  // longest time, so integer division rounds down
  localparam int WR_CYCLES = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WCNT_W = 18;
  localparam int T_SCL_NS = 1040;
  localparam int QTR_CYCLES = T_SCL_NS / 4 / CLK_PERIOD_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYCLES - 1);

  // ****************************************************************
  // memory layout and address word
  // ****************************************************************
  localparam int ADDR_W = 13;
  localparam int MEM_BYTES = 8192;
  localparam int ID_BYTES = 32;
  localparam logic [12:0] MASK_FULL = 13'h1fff;
  localparam logic [12:0] MASK_PAGE = 13'h001f;
  localparam logic [12:0] MASK_SN = 13'h000f;
  localparam logic [12:0] MASK_NONE = 13'h0000;
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_EXT = 4'hb;
  localparam int HI_SN_BIT = 3;
  localparam int HI_LOCK_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;
  localparam logic [1:0] AREA_NORM = 2'h0;
  localparam logic [1:0] AREA_ID = 2'h1;
  localparam logic [1:0] AREA_LOCK = 2'h2;
  localparam logic [1:0] AREA_SN = 2'h3;

  // ****************************************************************
  // master registers
  // ****************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CMD_ACK_BIT = 8;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h4;
  localparam logic [2:0] CMD_SRST = 3'h5;

  // ****************************************************************
  // state encodings
  // ****************************************************************
  typedef enum logic [5:0] {
    DS_IDLE = 6'h01, DS_RECV = 6'h02, DS_ACK = 6'h04,
    DS_SEND = 6'h08, DS_MACK = 6'h10, DS_BUSY = 6'h20
  } iew_dev_state_type;
  typedef enum logic [3:0] {
    PH_DEV = 4'h1, PH_AHI = 4'h2, PH_ALO = 4'h4, PH_DATA = 4'h8
  } iew_phase_type;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1, HS_START = 4'h2, HS_BITS = 4'h4, HS_STOP = 4'h8
  } iew_host_state_type;
endpackage

/* File: testbench/i2c_eeprom_write_addressing_test.sv */
// self-checking bench: apb master end driving the eeprom end across the link
module i2c_eeprom_write_addressing_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // set-up
  // ****************************************************************
  // long enough that at least one poll lands inside the write cycle
  localparam int WCYC = 1500;
  `define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, standby, write_busy;
  logic inhibit = 1'b0;
  logic [31:0] st;
  int err_count = 0;
  int num_checks = 0;
  int k;
  logic slverr_seen;
  // wrong chip select, wrong type, wrong chip select
  logic [7:0] bad_word [3] = '{8'ha2, 8'h9a, 8'hae};
  iew_link_if link();
  always #10 pclk = ~pclk;
  iew_apb_master iew_apb_master_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // straps select chip 101
  iew_eeprom_dev #(.WRITE_CYCLES(WCYC)) iew_eeprom_dev_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .chip_select_bit_2(1'b1), .chip_select_bit_1(1'b0),
    .chip_select_bit_0(1'b1), .write_inhibit_pin(inhibit), .standby(standby),
    .write_busy(write_busy));
  iew_link_monitor #(.WRITE_CYCLES(WCYC)) iew_link_monitor_inst (.pclk(pclk),
    .presetn(presetn), .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe),
    .standby(standby), .write_busy(write_busy));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    $display("Error wait expected done seen timeout");
    end_sim();
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    st = prdata;
    slverr_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic ak);
    int n;
    n = 0;
    apb(iew_pkg::REG_CMD, 1'b1, {23'h0, ak, 5'h0, c});
    do begin
      apb(iew_pkg::REG_STAT, 1'b0, 32'h0);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    if (n >= 400) hang();
  endtask
  task automatic txa(input logic [7:0] b, output logic ak);
    apb(iew_pkg::REG_TX, 1'b1, {24'h0, b});
    cmd(iew_pkg::CMD_WRITE, 1'b0);
    ak = st[1];
  endtask
  task automatic tx(input logic [7:0] b, input logic e);
    logic ak;
    txa(b, ak);
    `CHK("ack", e, ak)
  endtask
  task automatic rxb(input logic ak, input logic [7:0] e);
    cmd(iew_pkg::CMD_READ, ak);
    `CHK("rdata", e, st[15:8])
  endtask
  // counts refused polls, then leaves the bus stopped
  task automatic poll(output int n);
    logic ak;
    n = 0;
    ak = 1'b0;
    while (ak !== 1'b1 && n < 40) begin
      cmd(iew_pkg::CMD_START, 1'b0);
      txa(8'haa, ak);
      if (ak !== 1'b1) n++;
    end
    if (n >= 40) hang();
    cmd(iew_pkg::CMD_STOP, 1'b0);
  endtask
  task automatic addr(input logic [7:0] dw, input logic [7:0] hi, input logic [7:0] lo);
    cmd(iew_pkg::CMD_START, 1'b0);
    tx(dw, 1'b1);
    tx(hi, 1'b1);
    tx(lo, 1'b1);
  endtask
  task automatic rd(input logic [7:0] dw, input logic [7:0] hi, input logic [7:0] lo,
                    input logic [7:0] e);
    addr(dw, hi, lo);
    cmd(iew_pkg::CMD_START, 1'b0);
    tx(dw | 8'h01, 1'b1);
    rxb(1'b0, e);
    cmd(iew_pkg::CMD_STOP, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cmd(iew_pkg::CMD_START, 1'b0);
    tx(8'haa, 1'b1);
    cmd(iew_pkg::CMD_SRST, 1'b0);
    foreach (bad_word[i]) begin
      cmd(iew_pkg::CMD_START, 1'b0);
      tx(bad_word[i], 1'b0);
      cmd(iew_pkg::CMD_STOP, 1'b0);
    end
    addr(8'haa, 8'h00, 8'h45);
    for (int i = 0; i < 33; i++) tx(8'(i), 1'b1);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    poll(k);
    `CHK("polls", 1'b1, k > 0)
    addr(8'haa, 8'h00, 8'h40);
    cmd(iew_pkg::CMD_START, 1'b0);
    tx(8'hab, 1'b1);
    for (int i = 0; i < 32; i++) rxb(i < 31, (i == 5) ? 8'h20 : 8'((i - 5) & 31));
    cmd(iew_pkg::CMD_STOP, 1'b0);
    addr(8'haa, 8'h01, 8'h00);
    tx(8'h11, 1'b1);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    inhibit <= 1'b1;
    poll(k);
    addr(8'haa, 8'h01, 8'h00);
    tx(8'h5a, 1'b1);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    poll(k);
    `CHK("polls", 0, k)
    rd(8'haa, 8'h01, 8'h00, 8'h11);
    inhibit <= 1'b0;
    addr(8'hba, 8'h00, 8'h02);
    tx(8'h33, 1'b1);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    poll(k);
    addr(8'hba, 8'h04, 8'h00);
    tx(8'h02, 1'b1);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    poll(k);
    // the lock must outlive a reset of both ends
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    addr(8'hba, 8'h00, 8'h02);
    tx(8'h44, 1'b0);
    cmd(iew_pkg::CMD_STOP, 1'b0);
    poll(k);
    rd(8'hba, 8'h00, 8'h02, 8'h33);
    apb(8'h0c, 1'b0, 32'h0);
    `CHK("pslverr", 1'b1, slverr_seen)
    apb(iew_pkg::REG_TX, 1'b0, 32'h0);
    `CHK("pslverr", 1'b0, slverr_seen)
    `CHK("tx reg", 32'h000000bb, st)
    end_sim();
  end
endmodule

/* File: testbench/iew_link_monitor.sv */
// link checker: device timing on the two-wire line and the self-timed write cycle
module iew_link_monitor #(
  parameter int WRITE_CYCLES = 200
) (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  // device status
  input wire logic standby,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // helpers and checks
  // ****************************************************************
  // length of the current busy stretch, zeroed whenever the device is free
  int unsigned busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
  end
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_take_at_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took sda while scl high");
  a_free_at_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released sda while scl high");
  a_drive_delay: assert property ($fell(scl) |-> $stable(dev_sda_oe) [*2])
    else $error("device changed sda too soon after scl fall");
  a_start_quiet: assert property (s_start |-> !dev_sda_oe)
    else $error("device drives sda at start");
  a_busy_quiet: assert property (write_busy |-> !dev_sda_oe)
    else $error("device answered during write cycle");
  a_busy_bound: assert property ($fell(write_busy) |-> busy_cnt <= WRITE_CYCLES)
    else $error("write cycle too long");
  a_busy_standby: assert property ($fell(write_busy) |-> ##[0:2] standby)
    else $error("no standby after write cycle");
  a_standby_quiet: assert property (standby |-> !dev_sda_oe)
    else $error("device drives sda in standby");
  c_stop_write: cover property (s_stop ##[1:8] write_busy);
endmodule
